/* rtl/sfe_flash_dev.sv */
// device end: command decode, erase engine and read streaming
// Contract
// RULE1 - sector erase opcode fills 4 KiB with ones
// RULE2 - erase taken only with write enable latch
// RULE3 - addressed erase needs cs rise after address
// RULE4 - busy high through erase, low after
// RULE5 - status readable while erase runs
// RULE6 - finished erase clears write enable latch
// RULE7 - protected region refuses addressed erase
// RULE8 - block 64 KiB, half block 32 KiB
// RULE9 - both block opcodes decoded with address
// RULE10 - two chip erase opcodes erase everything
// RULE11 - chip erase needs cs rise after opcode
// RULE12 - any protection refuses chip erase
// RULE13 - opcode and address sampled on rising clock
// RULE14 - read data on io1, falling edge, msb first
// RULE15 - address increments per byte until cs
// RULE16 - reads ignored while a cycle runs
// RULE17 - fast read ignores io0 during dummies
// RULE18 - dual read drives two bits per clock
// RULE19 - host releases io0 before dual data
// RULE20 - write enable opcode sets the latch
// RULE21 - dual pair: msb on io1, lsb io0
// RULE22 - erase region aligned, low bits ignored
`timescale 1ns/1ns
module sfe_flash_dev
   import sfe_pkg::*;
#(
   parameter int MEM_AW = 16
) (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   sfe_link_if.device      link,
   input  wire logic [2:0] protect_range,
   output logic            busy,
   output logic            write_enable_latch
);
   typedef enum logic [5:0] {
      D_OPC    = 6'b000001,
      D_ADDR   = 6'b000010,
      D_DUMMY  = 6'b000100,
      D_DATA   = 6'b001000,
      D_WAIT   = 6'b010000,
      D_IGNORE = 6'b100000
   } sfe_dst_type;
   typedef struct packed {
      sfe_dst_type       st;
      logic [2:0]        s_sclk;
      logic [2:0]        s_cs;
      logic [2:0]        s_io;
      logic              f_sclk;
      logic              f_cs;
      logic              f_io;
      logic [5:0]        cnt;
      logic [7:0]        opc;
      logic [23:0]       addr;
      logic [7:0]        sh;
      logic [2:0]        ocnt;
      logic              out1;
      logic              out0;
      logic              oe1;
      logic              oe0;
      logic              busy;
      logic              write_enable_latch;
      logic [MEM_AW-1:0] er_ptr;
      logic [MEM_AW:0]   er_left;
   } sfe_dev_state_type;
   localparam int MEM_BYTES = 1 << MEM_AW;
   sfe_dev_state_type r;
   sfe_dev_state_type next_r;
   logic [7:0]        mem [0:MEM_BYTES-1];
   logic              sclk_chg;
   logic              cs_chg;
   logic              rise;
   logic              fall;
   logic              cs_rise;
   logic              bit_in;
   logic              is_erase;
   logic              prot;
   logic              dual;
   logic [7:0]        stat;
   logic [7:0]        op;
   logic [23:0]       na;
   logic [MEM_AW-1:0] msk;
   logic [MEM_AW-1:0] base;
   logic [MEM_AW:0]   rend;
   logic [MEM_AW:0]   top;
   logic [MEM_AW:0]   plo;
   int                rsz;
   always_comb begin
      next_r = r;
      next_r.s_sclk = {r.s_sclk[1:0], link.sclk};
      next_r.s_cs = {r.s_cs[1:0], link.cs_n};
      next_r.s_io = {r.s_io[1:0], link.serial_in_io0};
      if (r.s_sclk[1] == r.s_sclk[2]) next_r.f_sclk = r.s_sclk[2];
      if (r.s_cs[1] == r.s_cs[2]) next_r.f_cs = r.s_cs[2];
      if (r.s_io[1] == r.s_io[2]) next_r.f_io = r.s_io[2];
      sclk_chg = (r.s_sclk[1] == r.s_sclk[2]) && (r.s_sclk[2] != r.f_sclk);
      cs_chg = (r.s_cs[1] == r.s_cs[2]) && (r.s_cs[2] != r.f_cs);
      rise = sclk_chg && r.s_sclk[2];
      fall = sclk_chg && !r.s_sclk[2];
      cs_rise = cs_chg && r.s_cs[2];
      bit_in = next_r.f_io;
      op = {r.opc[6:0], bit_in};
      na = {r.addr[22:0], bit_in};
      dual = (r.opc == SFE_OP_DUAL);
      stat = 8'h00;
      stat[SFE_STAT_BUSY] = r.busy;
      stat[SFE_STAT_WLATCH] = r.write_enable_latch;
      stat[SFE_STAT_RANGE_LSB +: 3] = protect_range;
      // RULE8 region size per opcode
      case (r.opc)
         SFE_OP_SECTOR: rsz = SFE_SECTOR_AW;
         SFE_OP_HALF:   rsz = SFE_HALF_AW;
         SFE_OP_BLOCK:  rsz = SFE_BLOCK_AW;
         default:       rsz = MEM_AW;
      endcase
      // RULE9 RULE10 erase opcode decode
      case (r.opc)
         SFE_OP_SECTOR, SFE_OP_HALF, SFE_OP_BLOCK, SFE_OP_CHIP_A,
         SFE_OP_CHIP_B: is_erase = 1'b1;
         default:       is_erase = 1'b0;
      endcase
      msk = MEM_AW'((1 << rsz) - 1);
      // RULE22 aligned region base
      base = (rsz == MEM_AW) ? '0 : (r.addr[MEM_AW-1:0] & ~msk);
      rend = {1'b0, base} + {1'b0, msk};
      top = {1'b1, {MEM_AW{1'b0}}};
      plo = top - (top >> (3'd7 - protect_range));
      // RULE7 RULE12 protected top fraction
      prot = (protect_range != 3'd0) && (rend >= plo);
      // RULE1 RULE4 RULE6 erase walk
      if (r.busy) begin
         next_r.er_ptr = r.er_ptr + 1'b1;
         next_r.er_left = r.er_left - 1'b1;
         if (r.er_left == '0) begin
            next_r.busy = 1'b0;
            next_r.write_enable_latch = 1'b0;
         end
      end
      if (r.f_cs) begin
         next_r.st = D_OPC;
         next_r.cnt = 6'h00;
         next_r.oe0 = 1'b0;
         next_r.oe1 = 1'b0;
      end
      // RULE3 RULE11 execute only from wait
      if (cs_rise && (r.st == D_WAIT) && !r.busy) begin
         if (r.opc == SFE_OP_WREN) begin
            // RULE20 latch set
            next_r.write_enable_latch = 1'b1;
         end else if (r.opc == SFE_OP_WRDI) begin
            next_r.write_enable_latch = 1'b0;
         // RULE2 latch gates erase
         end else if (is_erase && r.write_enable_latch && !prot) begin
            next_r.busy = 1'b1;
            next_r.er_ptr = base;
            next_r.er_left = {1'b0, msk};
         end
      end else if (!r.f_cs && rise) begin
         // RULE13 shift on rising edge
         next_r.cnt = r.cnt + 6'h01;
         case (r.st)
            D_OPC: begin
               next_r.opc = op;
               if (r.cnt == 6'(SFE_OPC_BITS - 1)) begin
                  next_r.cnt = 6'h00;
                  // RULE5 status even when busy
                  if (op == SFE_OP_STATUS) begin
                     next_r.st = D_DATA;
                     next_r.sh = stat;
                     next_r.ocnt = 3'h0;
                  // RULE16 busy ignores the rest
                  end else if (r.busy) begin
                     next_r.st = D_IGNORE;
                  end else begin
                     case (op)
                        SFE_OP_READ, SFE_OP_FAST, SFE_OP_DUAL,
                        SFE_OP_SECTOR, SFE_OP_HALF, SFE_OP_BLOCK:
                           next_r.st = D_ADDR;
                        SFE_OP_CHIP_A, SFE_OP_CHIP_B, SFE_OP_WREN,
                        SFE_OP_WRDI:
                           next_r.st = D_WAIT;
                        default: next_r.st = D_IGNORE;
                     endcase
                  end
               end
            end
            D_ADDR: begin
               next_r.addr = na;
               if (r.cnt == 6'(SFE_ADDR_BITS - 1)) begin
                  next_r.cnt = 6'h00;
                  if (r.opc == SFE_OP_READ) begin
                     next_r.st = D_DATA;
                     next_r.sh = mem[na[MEM_AW-1:0]];
                     next_r.addr = na + 24'h000001;
                     next_r.ocnt = 3'h0;
                  end else if (is_erase) begin
                     next_r.st = D_WAIT;
                  end else begin
                     next_r.st = D_DUMMY;
                  end
               end
            end
            // RULE17 dummy bits not looked at
            D_DUMMY: begin
               if (r.cnt == 6'(SFE_DUMMY_CLKS - 1)) begin
                  next_r.st = D_DATA;
                  next_r.sh = mem[r.addr[MEM_AW-1:0]];
                  next_r.addr = r.addr + 24'h000001;
                  next_r.ocnt = 3'h0;
               end
            end
            D_WAIT: next_r.st = D_IGNORE;
            default: next_r.cnt = r.cnt;
         endcase
      end else if (!r.f_cs && fall && (r.st == D_DATA)) begin
         // RULE14 msb first on falling edge
         next_r.oe1 = 1'b1;
         next_r.out1 = r.sh[7];
         next_r.ocnt = r.ocnt + 3'h1;
         if (dual) begin
            // RULE18 RULE21 two bits per clock
            next_r.oe0 = 1'b1;
            next_r.out0 = r.sh[6];
            next_r.sh = {r.sh[5:0], 2'b00};
         end else begin
            next_r.sh = {r.sh[6:0], 1'b0};
         end
         if (r.ocnt == (dual ? 3'h3 : 3'h7)) begin
            next_r.ocnt = 3'h0;
            if (r.opc == SFE_OP_STATUS) begin
               next_r.sh = stat;
            end else begin
               // RULE15 next byte, address up
               next_r.sh = mem[r.addr[MEM_AW-1:0]];
               next_r.addr = r.addr + 24'h000001;
            end
         end
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.st <= D_OPC;
         r.s_sclk <= 3'b000;
         r.s_cs <= 3'b111;
         r.s_io <= 3'b111;
         r.f_cs <= 1'b1;
         r.f_io <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   // array storage, one erased byte per cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= SFE_MEM_RESET;
         end
      end else if (r.busy) begin
         mem[r.er_ptr] <= SFE_ERASED;
      end
   end
   assign busy = r.busy;
   assign write_enable_latch = r.write_enable_latch;
   assign link.dev_io1_out = r.out1;
   assign link.dev_io1_oe = r.oe1;
   assign link.dev_io0_out = r.out0;
   assign link.dev_io0_oe = r.oe0;
endmodule // sfe_flash_dev

/* common/sfe_pkg.sv */
// shared constants for the serial flash erase and read link
package sfe_pkg;
   localparam logic [7:0] SFE_OP_SECTOR = 8'h20;
   localparam logic [7:0] SFE_OP_HALF   = 8'h52;
   localparam logic [7:0] SFE_OP_BLOCK  = 8'hD8;
   localparam logic [7:0] SFE_OP_CHIP_A = 8'hC7;
   localparam logic [7:0] SFE_OP_CHIP_B = 8'h60;
   localparam logic [7:0] SFE_OP_READ   = 8'h03;
   localparam logic [7:0] SFE_OP_FAST   = 8'h0B;
   localparam logic [7:0] SFE_OP_DUAL   = 8'h3B;
   localparam logic [7:0] SFE_OP_WREN   = 8'h06;
   localparam logic [7:0] SFE_OP_WRDI   = 8'h04;
   localparam logic [7:0] SFE_OP_STATUS = 8'h05;
   localparam int SFE_SECTOR_AW  = 12;
   localparam int SFE_HALF_AW    = 15;
   localparam int SFE_BLOCK_AW   = 16;
   localparam int SFE_OPC_BITS   = 8;
   localparam int SFE_ADDR_BITS  = 24;
   localparam int SFE_DUMMY_CLKS = 8;
   localparam int SFE_STAT_BUSY      = 0;
   localparam int SFE_STAT_WLATCH    = 1;
   localparam int SFE_STAT_RANGE_LSB = 2;
   localparam logic [7:0] SFE_ERASED    = 8'hFF;
   localparam logic [7:0] SFE_MEM_RESET = 8'h00;
   localparam int SFE_SCLK_HALF = 8;
endpackage

/* common/sfe_link_if.sv */
// serial link between flash host and flash device
`timescale 1ns/1ns
interface sfe_link_if;
   logic cs_n;
   logic sclk;
   logic host_io0_out;
   logic host_io0_oe;
   logic dev_io0_out;
   logic dev_io0_oe;
   logic dev_io1_out;
   logic dev_io1_oe;
   logic serial_in_io0;
   logic serial_out_io1;
   // resolved pin levels, idle high
   assign serial_in_io0  = host_io0_oe ? host_io0_out :
                           (dev_io0_oe ? dev_io0_out : 1'b1);
   assign serial_out_io1 = dev_io1_oe ? dev_io1_out : 1'b1;
   modport device (input cs_n, input sclk, input serial_in_io0,
                   output dev_io0_out, output dev_io0_oe,
                   output dev_io1_out, output dev_io1_oe);
   modport host (output cs_n, output sclk, output host_io0_out,
                 output host_io0_oe, input serial_in_io0,
                 input serial_out_io1);
endinterface

/* rtl/sfe_flash_host.sv */
// host end: drives chip select, clock and commands, gathers read data
`timescale 1ns/1ns
module sfe_flash_host
   import sfe_pkg::*;
#(
   parameter int HALF = SFE_SCLK_HALF
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   sfe_link_if.host         link,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [7:0]  cmd_opcode,
   input  wire logic [23:0] cmd_addr,
   input  wire logic [15:0] cmd_len,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   output logic             done
);
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_LOW  = 5'b00010,
      H_HIGH = 5'b00100,
      H_END  = 5'b01000,
      H_GAP  = 5'b10000
   } sfe_hst_type;
   typedef struct packed {
      sfe_hst_type st;
      logic [7:0]  div;
      logic        cs_n;
      logic        sclk;
      logic        io0o;
      logic        io0oe;
      logic [39:0] tx;
      logic [19:0] clk;
      logic [19:0] txc;
      logic [19:0] drvc;
      logic [19:0] total;
      logic [7:0]  rx;
      logic [2:0]  rcnt;
      logic        dual;
      logic [7:0]  rdat;
      logic        rval;
      logic        done;
      logic [2:0]  s_io0;
      logic [2:0]  s_io1;
      logic        f_io0;
      logic        f_io1;
   } sfe_host_state_type;
   localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
   sfe_host_state_type r;
   sfe_host_state_type next_r;
   logic        has_addr;
   logic        has_dummy;
   logic        is_rd;
   logic [7:0]  rx_new;
   always_comb begin
      next_r = r;
      has_addr = 1'b0;
      has_dummy = 1'b0;
      is_rd = 1'b0;
      rx_new = r.rx;
      next_r.rval = 1'b0;
      next_r.done = 1'b0;
      // pin samplers, accepted when two stages agree
      next_r.s_io0 = {r.s_io0[1:0], link.serial_in_io0};
      next_r.s_io1 = {r.s_io1[1:0], link.serial_out_io1};
      if (r.s_io0[1] == r.s_io0[2]) next_r.f_io0 = r.s_io0[2];
      if (r.s_io1[1] == r.s_io1[2]) next_r.f_io1 = r.s_io1[2];
      case (cmd_opcode)
         SFE_OP_READ, SFE_OP_SECTOR, SFE_OP_HALF, SFE_OP_BLOCK:
            has_addr = 1'b1;
         SFE_OP_FAST, SFE_OP_DUAL: begin
            has_addr = 1'b1;
            has_dummy = 1'b1;
         end
         default: has_addr = 1'b0;
      endcase
      is_rd = (cmd_opcode == SFE_OP_READ) || (cmd_opcode == SFE_OP_FAST) ||
              (cmd_opcode == SFE_OP_DUAL) || (cmd_opcode == SFE_OP_STATUS);
      case (r.st)
         H_IDLE: begin
            if (cmd_valid) begin
               next_r.st = H_LOW;
               next_r.div = 8'h00;
               next_r.clk = 20'h00000;
               next_r.cs_n = 1'b0;
               next_r.tx = {cmd_opcode, cmd_addr, 8'h00};
               next_r.io0o = cmd_opcode[7];
               next_r.io0oe = 1'b1;
               next_r.dual = (cmd_opcode == SFE_OP_DUAL);
               next_r.rcnt = 3'h0;
               // RULE13 opcode then address
               next_r.drvc = 20'(SFE_OPC_BITS + (has_addr ? SFE_ADDR_BITS : 0));
               // RULE17 eight dummy clocks
               next_r.txc = 20'(SFE_OPC_BITS +
                                (has_addr ? SFE_ADDR_BITS : 0) +
                                (has_dummy ? SFE_DUMMY_CLKS : 0));
               next_r.total = next_r.txc + (is_rd ?
                  (next_r.dual ? {2'b00, cmd_len, 2'b00}
                               : {1'b0, cmd_len, 3'b000}) : 20'h00000);
            end
         end
         H_LOW: begin
            next_r.div = r.div + 8'h01;
            if (r.div == HALF_M1) begin
               next_r.div = 8'h00;
               next_r.sclk = 1'b1;
               next_r.st = H_HIGH;
            end
         end
         H_HIGH: begin
            next_r.div = r.div + 8'h01;
            if (r.div == HALF_M1) begin
               next_r.div = 8'h00;
               next_r.sclk = 1'b0;
               if (r.clk >= r.txc) begin
                  rx_new = r.dual ? {r.rx[5:0], r.f_io1, r.f_io0}
                                  : {r.rx[6:0], r.f_io1};
                  next_r.rx = rx_new;
                  next_r.rcnt = r.rcnt + (r.dual ? 3'h2 : 3'h1);
                  if (r.rcnt == (r.dual ? 3'h6 : 3'h7)) begin
                     next_r.rdat = rx_new;
                     next_r.rval = 1'b1;
                  end
               end
               next_r.clk = r.clk + 20'h00001;
               next_r.tx = {r.tx[38:0], 1'b0};
               next_r.io0o = r.tx[38];
               // RULE19 release io0 after address
               next_r.io0oe = (next_r.clk < r.drvc);
               // RULE3 close exactly after last bit
               next_r.st = (next_r.clk == r.total) ? H_END : H_LOW;
            end
         end
         H_END: begin
            next_r.div = r.div + 8'h01;
            if (r.div == HALF_M1) begin
               next_r.div = 8'h00;
               // RULE11 cs rises after last clock
               next_r.cs_n = 1'b1;
               next_r.io0oe = 1'b0;
               next_r.st = H_GAP;
            end
         end
         H_GAP: begin
            next_r.div = r.div + 8'h01;
            if (r.div == HALF_M1) begin
               next_r.done = 1'b1;
               next_r.st = H_IDLE;
            end
         end
         default: next_r.st = H_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.st <= H_IDLE;
         r.cs_n <= 1'b1;
         r.s_io0 <= 3'b111;
         r.s_io1 <= 3'b111;
         r.f_io0 <= 1'b1;
         r.f_io1 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   assign cmd_ready = (r.st == H_IDLE);
   assign rd_data = r.rdat;
   assign rd_valid = r.rval;
   assign done = r.done;
   assign link.cs_n = r.cs_n;
   assign link.sclk = r.sclk;
   assign link.host_io0_out = r.io0o;
   assign link.host_io0_oe = r.io0oe;
endmodule // sfe_flash_host

/* test/sfe_link_properties.sv */
// checker on the serial link between host and device ends
`timescale 1ns/1ns
module sfe_link_properties (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       host_io0_oe,
   input wire logic       dev_io0_oe,
   input wire logic       dev_io1_out,
   input wire logic       dev_io1_oe,
   input wire logic       busy,
   input wire logic       write_enable_latch,
   input wire logic [2:0] protect_range
);
   logic [16:0] busy_len;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // busy cycle counter
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy_len <= 17'h0;
      end else if (!busy) begin
         busy_len <= 17'h0;
      end else begin
         busy_len <= busy_len + 17'h1;
      end
   end
   property p_idle_sclk;
      cs_n |-> !sclk;
   endproperty
   a_idle_sclk: assert property (p_idle_sclk)
      else $error("serial clock high while deselected");
   property p_dev_quiet;
      cs_n [*6] |-> !dev_io1_oe && !dev_io0_oe;
   endproperty
   a_dev_quiet: assert property (p_dev_quiet)
      else $error("device drives a pin while deselected");
   property p_io1_change;
      !cs_n && $changed(dev_io1_out) |-> !sclk;
   endproperty
   a_io1_change: assert property (p_io1_change)
      else $error("output data changed while clock high");
   property p_no_contend;
      !(host_io0_oe && dev_io0_oe);
   endproperty
   a_no_contend: assert property (p_no_contend)
      else $error("both ends drive io0");
   property p_dual_pair;
      dev_io0_oe |-> dev_io1_oe;
   endproperty
   a_dual_pair: assert property (p_dual_pair)
      else $error("io0 driven without io1");
   property p_busy_wel;
      busy |-> write_enable_latch;
   endproperty
   a_busy_wel: assert property (p_busy_wel)
      else $error("erase running without write enable");
   property p_busy_cs;
      $rose(busy) |-> cs_n;
   endproperty
   a_busy_cs: assert property (p_busy_cs)
      else $error("erase started while selected");
   property p_busy_min;
      $rose(busy) |=> busy [*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("busy dropped early");
   property p_busy_len;
      $fell(busy) |-> busy_len == 17'h01000 || busy_len == 17'h08000
         || busy_len == 17'h10000;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("erase length not a region size");
   property p_wel_clear;
      $fell(busy) |-> !write_enable_latch;
   endproperty
   a_wel_clear: assert property (p_wel_clear)
      else $error("latch kept after erase");
   property p_prot_all;
      $rose(busy) |-> protect_range != 3'h7;
   endproperty
   a_prot_all: assert property (p_prot_all)
      else $error("erase started with full protection");
   property p_wel_set;
      $rose(write_enable_latch) |-> cs_n && !busy;
   endproperty
   a_wel_set: assert property (p_wel_set)
      else $error("latch set mid command or while busy");
endmodule // sfe_link_properties

/* test/test_spi_flash_erase_read_cmds.sv */
// bench driving host commands across the link to the device end
`timescale 1ns/1ns
module test_spi_flash_erase_read_cmds
   import sfe_pkg::*;
;
   logic        sys_clk;
   logic        reset;
   logic        cmd_valid;
   logic        cmd_ready;
   logic [7:0]  cmd_opcode;
   logic [23:0] cmd_addr;
   logic [15:0] cmd_len;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        done;
   logic [2:0]  protect_range;
   logic        busy;
   logic        write_enable_latch;
   int          err_total;
   int          checks_done;
   logic [7:0]  q[$];
   logic [7:0]  ops[4];
   logic [23:0] adrs[4];
   sfe_link_if link ();
   sfe_flash_host sfe_flash_host_i (.sys_clk(sys_clk), .reset(reset),
      .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
   sfe_flash_dev #(.MEM_AW(16)) sfe_flash_dev_i (.sys_clk(sys_clk),
      .reset(reset), .link(link), .protect_range(protect_range),
      .busy(busy), .write_enable_latch(write_enable_latch));
   sfe_link_properties sfe_link_properties_i (.sys_clk(sys_clk),
      .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
      .host_io0_oe(link.host_io0_oe), .dev_io0_oe(link.dev_io0_oe),
      .dev_io1_out(link.dev_io1_out), .dev_io1_oe(link.dev_io1_oe),
      .busy(busy), .write_enable_latch(write_enable_latch),
      .protect_range(protect_range));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic results();
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bail();
      err_total++;
      results();
   endtask
   // one whole command, read bytes gathered in q
   task automatic cmd(input logic [7:0] op, input logic [23:0] adr,
                      input logic [15:0] len);
      int n;
      q.delete();
      n = 0;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 100) bail();
      end
      cmd_opcode = op;
      cmd_addr = adr;
      cmd_len = len;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1) begin
         @(negedge sys_clk);
         if (rd_valid === 1'b1) q.push_back(rd_data);
         n++;
         if (n > 20000) bail();
      end
   endtask
   task automatic status(input logic [7:0] exp);
      cmd(SFE_OP_STATUS, 24'h0, 16'h1);
      chk(q[0], exp);
   endtask
   task automatic rd4(input logic [7:0] op, input logic [23:0] adr,
                      input logic [31:0] exp);
      cmd(op, adr, 16'h4);
      for (int i = 0; i < 4; i++) begin
         chk(q[i], exp[31-8*i -: 8]);
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      q = {8'h01};
      while (q[0][SFE_STAT_BUSY] !== 1'b0) begin
         cmd(SFE_OP_STATUS, 24'h0, 16'h1);
         n++;
         if (n > 300) bail();
      end
   endtask
   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_opcode = 8'h00;
      cmd_addr = 24'h0;
      cmd_len = 16'h0;
      protect_range = 3'h0;
      err_total = 0;
      checks_done = 0;
      ops = '{SFE_OP_CHIP_A, SFE_OP_CHIP_B, SFE_OP_BLOCK, SFE_OP_HALF};
      adrs = '{24'h0, 24'h0, 24'h00F000, 24'h008123};
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      status(8'h00);
      cmd(SFE_OP_SECTOR, 24'h001000, 16'h0);
      status(8'h00);
      chk({7'h0, busy}, 8'h00);
      cmd(SFE_OP_WREN, 24'h0, 16'h0);
      status(8'h02);
      protect_range = 3'h1;
      for (int i = 0; i < 4; i++) begin
         cmd(ops[i], adrs[i], 16'h0);
         status(8'h06);
      end
      cmd(SFE_OP_SECTOR, 24'h00FC00, 16'h0);
      status(8'h06);
      protect_range = 3'h0;
      cmd(SFE_OP_SECTOR, 24'h001234, 16'h0);
      rd4(SFE_OP_READ, 24'h000000, 32'hFFFFFFFF);
      status(8'h03);
      chk({7'h0, busy}, 8'h01);
      wait_idle();
      status(8'h00);
      chk({7'h0, write_enable_latch}, 8'h00);
      rd4(SFE_OP_READ, 24'h000FFE, 32'h0000FFFF);
      rd4(SFE_OP_READ, 24'h001FFE, 32'hFFFF0000);
      cmd(SFE_OP_WREN, 24'h0, 16'h0);
      cmd(SFE_OP_HALF, 24'h00A5A5, 16'h0);
      wait_idle();
      status(8'h00);
      rd4(SFE_OP_FAST, 24'h007FFE, 32'h0000FFFF);
      rd4(SFE_OP_DUAL, 24'h007FFE, 32'h0000FFFF);
      rd4(SFE_OP_DUAL, 24'h00FFFE, 32'hFFFF0000);
      results();
   end
endmodule // test_spi_flash_erase_read_cmds
